// ===== common/mlp_pkg.sv
package mlp_pkg;

  // ----------------------------------------
  // Management frame layout
  // ----------------------------------------
  localparam int          DATA_W      = 16;
  localparam int          RA_W        = 5;
  localparam int          HDR_W       = 12;
  localparam int          PRE_W       = 6;
  localparam logic [5:0]  PRE_BITS    = 6'h20;
  localparam logic [4:0]  CNT_LAST    = 5'h0F;
  localparam logic [1:0]  OP_READ     = 2'h2;
  localparam logic [1:0]  OP_WRITE    = 2'h1;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [4:0]  RA_LOS_CTL  = 5'h0E;
  localparam logic [4:0]  RA_LOS_STAT = 5'h0F;
  localparam logic [4:0]  RA_EXT_PTR  = 5'h1E;
  localparam logic [4:0]  RA_EXT_WIN  = 5'h1F;
  localparam logic [15:0] EXT_BASE    = 16'h8000;
  localparam int          EXT_N       = 4;
  localparam int          EXT_IDX_W   = 2;
  localparam logic [15:0] EXT_PTR_RST = 16'h8000;
  localparam logic [15:0] EXT_MEM_RST = 16'h0000;
  localparam int          LOS_EN_W    = 6;
  localparam logic [5:0]  LOS_EN_RST  = 6'h01;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MLP_IDLE,
    MLP_START,
    MLP_HDR,
    MLP_TA,
    MLP_DATA
  } mlp_state_t;

  typedef struct packed {
    logic sig_below_thr;
    logic chan_sync_lost;
    logic pll_unlock_ls;
    logic pll_unlock_hs;
    logic decode_err;
    logic gain_loop_locked;
    logic autozero_cal_done;
  } mlp_los_src_t;

  typedef struct packed {
    logic az_fail;
    logic agc_fail;
    logic decode;
    logic pll;
    logic sync;
    logic detect;
  } mlp_los_en_t;

  typedef struct packed {
    logic raw_los;
    logic loss_out;
  } mlp_los_stat_t;

endpackage

// ===== rtl/mlp_los_chan.sv
`timescale 1ns/10ps
module mlp_los_chan (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Enables from management
  input  wire mlp_pkg::mlp_los_en_t   los_en,
  // Raw status sources
  input  wire mlp_pkg::mlp_los_src_t  src,
  // Results
  output      mlp_pkg::mlp_los_stat_t stat,
  output      logic                   loss_out
);
  import mlp_pkg::*;

  typedef struct packed {
    mlp_los_src_t s1;
    mlp_los_src_t s2;
    logic         out;
  } mlp_chan_st_t;

  mlp_chan_st_t st_ff;
  mlp_chan_st_t nxt_st_ff;

  // ----------------------------------------
  // Synchronise, combine, register
  // ----------------------------------------
  always_comb begin
    nxt_st_ff    = st_ff;
    nxt_st_ff.s1 = src;
    nxt_st_ff.s2 = st_ff.s1;
    nxt_st_ff.out =
        (los_en.detect   & st_ff.s2.sig_below_thr)        // [R01]
      | (los_en.sync     & st_ff.s2.chan_sync_lost)       // [R03]
      | (los_en.pll      & (st_ff.s2.pll_unlock_ls
                          | st_ff.s2.pll_unlock_hs))      // [R04]
      | (los_en.decode   & st_ff.s2.decode_err)           // [R05]
      | (los_en.agc_fail & ~st_ff.s2.gain_loop_locked)    // [R06]
      | (los_en.az_fail  & ~st_ff.s2.autozero_cal_done);  // [R07] [R08]
    if (sys_rst) begin
      nxt_st_ff = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st_ff;
  end

  assign loss_out      = st_ff.out;
  assign stat.loss_out = st_ff.out;
  assign stat.raw_los  = st_ff.s2.sig_below_thr;              // [R02]

endmodule

// ===== rtl/mlp_mgmt_los.sv
`timescale 1ns/10ps
// Functional notes
// R01: With detection on, loss is flagged below 75 mVpp, cleared above 150.
// R02: Each channel's loss indication can be read over management.
// R03: Channel sync loss may be ORed into the loss pin, off after reset.
// R04: Low and high speed PLL unlock may be ORed in, off by default.
// R05: Receive 8b/10b decode errors may be ORed in, off by default.
// R06: An unlocked gain loop may be ORed in, off by default.
// R07: Unfinished auto-zero calibration may be ORed in, off by default.
// R08: Each pin is high on any enabled failure; both channels match.
// R09: Frames are answered only when address bits 4:1 match the straps.
// R10: Address bit 0 picks channel A (0) or channel B (1).
// R11: Writes to bad registers, other devices or read-only bits vanish.
// R12: Reads of bad registers return all zero.
// R13: The first turnaround bit of a read is left undriven.
// R14: The controller loads the pointer at 0x1E before using the window.
// R15: The window at 0x1F reads and writes the pointed extended register.
// R16: Registers 0x01-0x15 and 0x1D follow the channel, others are global.
// R17: The pointer keeps its value across frames until rewritten.
module mlp_mgmt_los (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Management pins
  input  wire logic                  mdc,
  input  wire logic                  mdio_in,
  output      logic                  mdio_out,
  output      logic                  mdio_oe,
  input  wire logic [4:0]            port_address_straps,
  // Loss status sources
  input  wire mlp_pkg::mlp_los_src_t los_src_a,
  input  wire mlp_pkg::mlp_los_src_t los_src_b,
  // Loss pins
  output      logic                  signal_loss_out_chan_a,
  output      logic                  signal_loss_out_chan_b
);
  import mlp_pkg::*;

  typedef struct packed {
    logic [1:0]                      mdc_sy;
    logic [1:0]                      mdio_sy;
    logic [3:0]                      strap_s1;
    logic [3:0]                      strap_s2;
    logic                            mdc_prev;
    mlp_state_t                      st;
    logic [PRE_W-1:0]                pre_cnt;
    logic [4:0]                      cnt;
    logic [HDR_W-1:0]                hdr;
    logic [DATA_W-1:0]               sh;
    logic                            out;
    logic                            oe;
    logic [DATA_W-1:0]               ext_ptr;
    logic [EXT_N-1:0][DATA_W-1:0]    ext_mem;
    logic [1:0][LOS_EN_W-1:0]        los_en;
    logic [1:0]                      loss_lh;
  } mlp_top_st_t;

  mlp_top_st_t        st_ff;
  mlp_top_st_t        nxt_st_ff;
  mlp_los_src_t [1:0] src_arr;
  mlp_los_stat_t [1:0] stat_arr;
  logic [1:0]         loss_arr;
  logic               mdc_rise;
  logic               bit_in;
  logic [HDR_W-1:0]   hdr_nxt;
  logic [DATA_W-1:0]  sh_nxt;
  logic               match;
  logic               ch;
  logic [RA_W-1:0]    ra;
  logic [1:0]         op;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic ext_hit(input logic [DATA_W-1:0] ptr);
    ext_hit = (ptr[DATA_W-1:EXT_IDX_W] == EXT_BASE[DATA_W-1:EXT_IDX_W]);
  endfunction

  function automatic logic [DATA_W-1:0] read_reg(
    input logic [RA_W-1:0] addr,
    input logic            c
  );
    read_reg = '0;                                             // [R12]
    case (addr)
      RA_LOS_CTL: begin
        read_reg[LOS_EN_W-1:0] = st_ff.los_en[c];              // [R16]
      end
      RA_LOS_STAT: begin
        read_reg[0] = stat_arr[c].raw_los;                     // [R02]
        read_reg[1] = stat_arr[c].loss_out;
        read_reg[2] = st_ff.loss_lh[c];
      end
      RA_EXT_PTR: begin
        read_reg = st_ff.ext_ptr;
      end
      RA_EXT_WIN: begin
        if (ext_hit(st_ff.ext_ptr)) begin                      // [R15]
          read_reg = st_ff.ext_mem[st_ff.ext_ptr[EXT_IDX_W-1:0]];
        end
      end
      default: begin
        read_reg = '0;
      end
    endcase
  endfunction

  // ----------------------------------------
  // Loss indication per channel
  // ----------------------------------------
  assign src_arr = {los_src_b, los_src_a};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_chan
      mlp_los_chan u_chan (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .los_en   (mlp_los_en_t'(st_ff.los_en[i])),
        .src      (src_arr[i]),
        .stat     (stat_arr[i]),
        .loss_out (loss_arr[i])
      );
    end
  endgenerate

  assign signal_loss_out_chan_a = loss_arr[0];
  assign signal_loss_out_chan_b = loss_arr[1];
  assign mdio_out               = st_ff.out;
  assign mdio_oe                = st_ff.oe;

  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  always_comb begin
    nxt_st_ff          = st_ff;
    nxt_st_ff.mdc_sy   = {st_ff.mdc_sy[0], mdc};
    nxt_st_ff.mdio_sy  = {st_ff.mdio_sy[0], mdio_in};
    nxt_st_ff.strap_s1 = port_address_straps[4:1];
    nxt_st_ff.strap_s2 = st_ff.strap_s1;
    nxt_st_ff.mdc_prev = st_ff.mdc_sy[1];
    mdc_rise = st_ff.mdc_sy[1] & ~st_ff.mdc_prev;
    bit_in   = st_ff.mdio_sy[1];
    hdr_nxt  = {st_ff.hdr[HDR_W-2:0], bit_in};
    sh_nxt   = {st_ff.sh[DATA_W-2:0], bit_in};
    op       = st_ff.hdr[11:10];
    ch       = st_ff.hdr[5];                                   // [R10]
    ra       = st_ff.hdr[4:0];
    match    = (st_ff.hdr[9:6] == st_ff.strap_s2);             // [R09]

    // Sticky loss flag, set beats clear-on-read
    for (int c = 0; c < 2; c++) begin
      nxt_st_ff.loss_lh[c] = st_ff.loss_lh[c] | loss_arr[c];
    end

    if (mdc_rise) begin
      case (st_ff.st)
        MLP_IDLE: begin
          if (bit_in) begin
            if (st_ff.pre_cnt != PRE_BITS) begin
              nxt_st_ff.pre_cnt = st_ff.pre_cnt + 1'b1;
            end
          end else begin
            nxt_st_ff.pre_cnt = '0;
            if (st_ff.pre_cnt == PRE_BITS) begin
              nxt_st_ff.st = MLP_START;
            end
          end
        end
        MLP_START: begin
          nxt_st_ff.cnt = '0;
          nxt_st_ff.st  = bit_in ? MLP_HDR : MLP_IDLE;
        end
        MLP_HDR: begin
          nxt_st_ff.hdr = hdr_nxt;
          nxt_st_ff.cnt = st_ff.cnt + 1'b1;
          if (st_ff.cnt == 5'(HDR_W - 1)) begin
            nxt_st_ff.cnt = '0;
            nxt_st_ff.st  = MLP_TA;
            nxt_st_ff.oe  = 1'b0;                              // [R13]
            nxt_st_ff.sh  = read_reg(hdr_nxt[4:0], hdr_nxt[5]);
            if (hdr_nxt[11:10] == OP_READ &&
                hdr_nxt[9:6] == st_ff.strap_s2 &&
                hdr_nxt[4:0] == RA_LOS_STAT) begin
              nxt_st_ff.loss_lh[hdr_nxt[5]] = loss_arr[hdr_nxt[5]];
            end
          end
        end
        MLP_TA: begin
          if (st_ff.cnt == '0) begin
            nxt_st_ff.cnt = 5'h01;
            nxt_st_ff.out = 1'b0;
            nxt_st_ff.oe  = (op == OP_READ) && match;          // [R13]
          end else begin
            nxt_st_ff.cnt = '0;
            nxt_st_ff.st  = MLP_DATA;
            nxt_st_ff.out = st_ff.sh[DATA_W-1];
            nxt_st_ff.oe  = (op == OP_READ) && match;
          end
        end
        MLP_DATA: begin
          nxt_st_ff.sh  = sh_nxt;
          nxt_st_ff.cnt = st_ff.cnt + 1'b1;
          nxt_st_ff.out = sh_nxt[DATA_W-1];
          if (st_ff.cnt == CNT_LAST) begin
            nxt_st_ff.st      = MLP_IDLE;
            nxt_st_ff.oe      = 1'b0;
            nxt_st_ff.out     = 1'b0;
            nxt_st_ff.pre_cnt = '0;
            if (op == OP_WRITE && match) begin                 // [R11]
              case (ra)
                RA_LOS_CTL: begin
                  nxt_st_ff.los_en[ch] = sh_nxt[LOS_EN_W-1:0]; // [R08] [R16]
                end
                RA_EXT_PTR: begin
                  nxt_st_ff.ext_ptr = sh_nxt;                  // [R17]
                end
                RA_EXT_WIN: begin
                  if (ext_hit(st_ff.ext_ptr)) begin            // [R15]
                    nxt_st_ff.ext_mem[st_ff.ext_ptr[EXT_IDX_W-1:0]] =
                      sh_nxt;
                  end
                end
                default: begin
                  nxt_st_ff.st = MLP_IDLE;                     // [R11]
                end
              endcase
            end
          end
        end
        default: begin
          nxt_st_ff.st = MLP_IDLE;
        end
      endcase
    end

    if (sys_rst) begin
      nxt_st_ff         = '0;
      nxt_st_ff.st      = MLP_IDLE;
      nxt_st_ff.ext_ptr = EXT_PTR_RST;
      for (int c = 0; c < 2; c++) begin
        nxt_st_ff.los_en[c] = LOS_EN_RST;                      // [R03]
      end
      for (int k = 0; k < EXT_N; k++) begin
        nxt_st_ff.ext_mem[k] = EXT_MEM_RST;
      end
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st_ff;
  end

endmodule

// ===== verif/mlp_mgmt_los_chk.sv
`timescale 1ns/10ps
module mlp_mgmt_los_chk (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  sys_rst,
  // Management pins
  input wire logic                  mdc,
  input wire logic                  mdio_out,
  input wire logic                  mdio_oe,
  // Loss path
  input wire mlp_pkg::mlp_los_src_t los_src_a,
  input wire mlp_pkg::mlp_los_src_t los_src_b,
  input wire logic                  signal_loss_out_chan_a,
  input wire logic                  signal_loss_out_chan_b
);
  import mlp_pkg::*;
  localparam logic [6:0] HLT  = 7'h03;
  localparam logic [6:0] ALLF = 7'h7C;
  logic       mdc_q_ff;
  logic [7:0] since_ff;
  // ----
  // Clocks since the last management clock rise
  // ----
  always_ff @(posedge clk) begin
    mdc_q_ff <= mdc;
    if (sys_rst || (mdc && !mdc_q_ff)) begin
      since_ff <= 8'h00;
    end else if (since_ff != 8'hFF) begin
      since_ff <= since_ff + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_rst_quiet: assert property (disable iff (1'b0)
    sys_rst |=> !mdio_oe && !signal_loss_out_chan_a && !signal_loss_out_chan_b)
    else $error("outputs active after reset");
  chk_clear_a: assert property (
    (los_src_a == HLT) [*4] |=> !signal_loss_out_chan_a)
    else $error("pin a high with healthy sources");
  chk_clear_b: assert property (
    (los_src_b == HLT) [*4] |=> !signal_loss_out_chan_b)
    else $error("pin b high with healthy sources");
  chk_fail_a: assert property (
    (los_src_a == ALLF) [*4] |=> signal_loss_out_chan_a)
    else $error("pin a low with all sources failing");
  chk_fail_b: assert property (
    (los_src_b == ALLF) [*4] |=> signal_loss_out_chan_b)
    else $error("pin b low with all sources failing");
  chk_oe_timing: assert property (
    $changed(mdio_oe) |-> since_ff inside {[0:6]})
    else $error("drive enable moved away from clock rise");
  chk_out_timing: assert property (
    $changed(mdio_out) |-> since_ff inside {[0:6]})
    else $error("data moved away from clock rise");
  chk_ta_zero: assert property (
    $rose(mdio_oe) |-> !mdio_out)
    else $error("second turnaround bit not zero");
  chk_idle_free: assert property (
    since_ff == 8'hFF |-> !mdio_oe)
    else $error("line driven while clock idle");
  cover property ($rose(mdio_oe));
  cover property ($rose(signal_loss_out_chan_a));
  cover property ($rose(signal_loss_out_chan_b));
endmodule
bind mlp_mgmt_los mlp_mgmt_los_chk mlp_mgmt_los_chk_i (
  .clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .los_src_a(los_src_a), .los_src_b(los_src_b),
  .signal_loss_out_chan_a(signal_loss_out_chan_a),
  .signal_loss_out_chan_b(signal_loss_out_chan_b));

// ===== verif/mlp_mdio_ctl.sv
`timescale 1ns/10ps
module mlp_mdio_ctl (
  // Management pins
  output logic      mdc,
  output wire logic mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  logic drv;
  logic dv;
  // Pull-up wins when nobody drives
  assign mdio_in = mdio_oe ? mdio_out : (drv ? dv : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    dv = 1'b1;
  end
  // ----
  // One whole frame, 400 ns bit time
  // ----
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd, output logic ta1);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    ta1 = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      drv = !(op == 2'b10 && i < 18);
      dv = f[i];
      #200;
      if (i == 17) ta1 = mdio_in;
      if (i < 16) rd[i] = mdio_in;
      mdc = 1'b1;
      #200;
      mdc = 1'b0;
    end
    drv = 1'b0;
  endtask
endmodule

// ===== verif/mlp_mgmt_los_tb.sv
`timescale 1ns/10ps
module mlp_mgmt_los_tb;
  import mlp_pkg::*;
  localparam logic [4:0] PA_A = 5'h16;
  localparam logic [4:0] PA_B = 5'h17;
  localparam logic [6:0] HLT  = 7'h03;
  logic         clk;
  logic         sys_rst;
  logic         mdc;
  logic         mdio_in;
  logic         mdio_out;
  logic         mdio_oe;
  logic [4:0]   straps;
  mlp_los_src_t src_a;
  mlp_los_src_t src_b;
  logic         los_a;
  logic         los_b;
  int           failures = 0;
  int           num_checks = 0;
  int           cyc = 0;
  mlp_mgmt_los mlp_mgmt_los_i (
    .clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .port_address_straps(straps), .los_src_a(src_a), .los_src_b(src_b),
    .signal_loss_out_chan_a(los_a), .signal_loss_out_chan_b(los_b));
  mlp_mdio_ctl mlp_mdio_ctl_i (.mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      $display("unexpected at %0t: run too long", $time);
      tally_and_finish();
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  task automatic pins(input logic a, input logic b, input string what);
    cmp({14'h0, los_a, los_b}, {14'h0, a, b}, what);
  endtask
  task automatic drive(input logic [6:0] a, input logic [6:0] b);
    @(negedge clk);
    src_a = a;
    src_b = b;
    repeat (4) @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra,
                    input logic [15:0] d);
    logic [15:0] x;
    logic t;
    mlp_mdio_ctl_i.frame(OP_WRITE, pa, ra, d, x, t);
  endtask
  task automatic rd(input logic [4:0] pa, input logic [4:0] ra,
                    input logic [15:0] m, input logic [15:0] e,
                    input string what);
    logic [15:0] x;
    logic t;
    mlp_mdio_ctl_i.frame(OP_READ, pa, ra, 16'h0000, x, t);
    cmp({15'h0, t}, 16'h0001, "turnaround");
    cmp(x & m, e, what);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_defaults();
    pins(1'b0, 1'b0, "idle pins");
    rd(PA_A, RA_LOS_CTL, 16'hFFFF, LOS_EN_RST, "ctl a");
    rd(PA_B, RA_LOS_CTL, 16'hFFFF, LOS_EN_RST, "ctl b");
    rd(PA_A, RA_EXT_PTR, 16'hFFFF, EXT_PTR_RST, "ptr");
  endtask
  task automatic t_sources();
    logic [6:0] m [7] = '{7'h40, 7'h20, 7'h10, 7'h04, 7'h02, 7'h01, 7'h08};
    logic [6:0] g [7] = '{7'h40, 7'h20, 7'h18, 7'h04, 7'h02, 7'h01, 7'h18};
    int e [7] = '{0, 1, 2, 3, 4, 5, 2};
    for (int k = 0; k < 7; k++) begin
      wr(PA_A, RA_LOS_CTL, 16'h0001 << e[k]);
      wr(PA_B, RA_LOS_CTL, 16'h0001 << e[k]);
      drive(HLT ^ m[k], HLT);
      pins(1'b1, 1'b0, "fail on a");
      drive(HLT, HLT ^ m[k]);
      pins(1'b0, 1'b1, "fail on b");
      drive(7'h7C ^ g[k], 7'h7C ^ g[k]);
      pins(1'b0, 1'b0, "others off");
      drive(7'h7C, 7'h7C);
      pins(1'b1, 1'b1, "all fail");
    end
    drive(HLT, HLT);
  endtask
  task automatic t_status();
    wr(PA_A, RA_LOS_CTL, 16'h0001);
    drive(HLT ^ 7'h40, HLT);
    rd(PA_A, RA_LOS_STAT, 16'h0003, 16'h0003, "stat a");
    rd(PA_B, RA_LOS_STAT, 16'h0003, 16'h0000, "stat b");
    drive(HLT, HLT);
    rd(PA_A, RA_LOS_STAT, 16'h0007, 16'h0004, "sticky set");
    rd(PA_A, RA_LOS_STAT, 16'h0007, 16'h0000, "sticky gone");
  endtask
  task automatic t_refuse();
    wr(PA_A ^ 5'h10, RA_LOS_CTL, 16'h0020);
    rd(PA_A ^ 5'h10, RA_LOS_CTL, 16'hFFFF, 16'hFFFF, "foreign");
    wr(PA_A, RA_LOS_STAT, 16'hFFFF);
    wr(PA_A, 5'h03, 16'h1234);
    rd(PA_A, 5'h03, 16'hFFFF, 16'h0000, "unmapped");
    rd(PA_A, RA_LOS_CTL, 16'hFFFF, 16'h0001, "ctl kept");
  endtask
  task automatic t_ext();
    wr(PA_A, RA_EXT_PTR, 16'h8002);
    wr(PA_B, RA_EXT_WIN, 16'hA5C3);
    wr(PA_A, RA_EXT_PTR, 16'h8003);
    wr(PA_A, RA_EXT_WIN, 16'h1234);
    wr(PA_A, RA_EXT_PTR, 16'h8002);
    rd(PA_A, RA_EXT_WIN, 16'hFFFF, 16'hA5C3, "window");
    rd(PA_B, RA_EXT_WIN, 16'hFFFF, 16'hA5C3, "again");
    rd(PA_B, RA_EXT_PTR, 16'hFFFF, 16'h8002, "ptr");
    wr(PA_A, RA_EXT_PTR, 16'h8009);
    wr(PA_A, RA_EXT_WIN, 16'hFFFF);
    rd(PA_A, RA_EXT_WIN, 16'hFFFF, 16'h0000, "outside");
  endtask
  initial begin
    sys_rst = 1'b1;
    straps = PA_A;
    src_a = HLT;
    src_b = HLT;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    t_defaults();
    t_sources();
    t_status();
    t_refuse();
    t_ext();
    repeat (300) @(negedge clk);
    tally_and_finish();
  end
endmodule
